// ---- rtl/async_serial_port_nine_bit.sv ----
// Nine-bit asynchronous serial port with AHB-Lite register access
`timescale 1ns/100ps
`include "serial_port_consts.svh"

// Notes on behaviour
// - Eleven-bit frame: start, eight LSB-first, ninth, stop.
// - Received ninth bit stored in status.
// - Oscillator mode baud is clock/32 or /64.
// - Buffer write starts; bits align to slice rollover.
// - Transmit done set as stop bit starts.
// - Receive only when enabled; start on falling edge.
// - Falling edge resets slice counter immediately.
// - Bit is majority of slices seven, eight, nine.
// - Two select bits choose four modes.
// - Missing stop bit flags framing error.
// - Control bit seven maps via access select.
// - Framing error only set by hardware, software clears.
// - Multiprocessor nine-bit modes need address match.
// - Address frames carry ninth bit high.
// - Multiprocessor off: every frame sets receive done.
// - Ten-bit multiprocessor: valid stop and address match.
// - Ten-bit mode stores stop bit as ninth.
// - Timer modes baud is overflow/16 or /32.
module async_serial_port_nine_bit (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        timerOverflow,
    input  wire logic        rxdPin,
    output logic             txdPin
);
    import serial_port_pkg::*;

    // ============================================================
    // Register state
    logic        msLo_r;
    logic        msHi_r;
    logic        mpEn_r;
    logic        rxEn_r;
    logic        tx9_r;
    logic        rx9_r;
    logic        txDone_r;
    logic        rxDone_r;
    logic        frameErr_r;
    logic        feAccSel_r;
    logic        baudDbl_r;
    logic [7:0]  txBuf_r;
    logic [7:0]  rxBuf_r;
    logic [7:0]  givenAddr_r;
    logic [7:0]  bcastAddr_r;
    logic       wrPend_r;
    logic [11:0] wrAddr_r;

    // Serial datapath state
    logic [4:0] oscDiv_r;
    logic       tmrHalf_r;
    logic [3:0] txSlice_r;
    logic [3:0] rxSlice_r;
    logic       txBusy_r;
    logic       txArm_r;
    logic [3:0] txCount_r;
    logic [9:0] txShift_r;
    rx_state_t  rxState_r;
    logic [3:0] rxCount_r;
    logic [8:0] rxShift_r;
    logic [2:0] vote_r;
    logic       rxPrev_r;
    logic       rxLine;

    // ============================================================
    // Pin synchroniser
    rx_sync u_rx_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pinIn   (rxdPin),
        .pinSync (rxLine)
    );

    // ============================================================
    // Shared helpers
    // Majority of three slices so one noisy sample cannot flip a bit
    function automatic logic majority3(input logic [2:0] s);
        majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Address compare, shared by the given and broadcast checks
    function automatic logic byteMatch(input logic [7:0] a, input logic [7:0] b);
        byteMatch = (a == b);
    endfunction

    // ============================================================
    // Bus decode
    // Reads answer at once; writes land one cycle later in the data phase
    wire   busTake  = hsel && hready && htrans[1];
    wire   busWrite = busTake && hwrite;
    wire   wrSctl   = wrPend_r && (wrAddr_r == `OFF_SCTL);
    wire   wrSbuf   = wrPend_r && (wrAddr_r == `OFF_SERIAL_BUFFER);
    wire   wrPwr    = wrPend_r && (wrAddr_r == `OFF_PWR);
    wire   wrGiven  = wrPend_r && (wrAddr_r == `OFF_ADDR);
    wire   wrBcast  = wrPend_r && (wrAddr_r == `OFF_BCAST);
    // No wait states: every address phase is taken at once
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire   [1:0] modeBits = {msHi_r, msLo_r};
    wire   isAsync  = (modeBits != MODE_SYNC);
    wire   is11     = (modeBits == MODE_OSC11) || (modeBits == MODE_TMR11);
    wire   useTimer = (modeBits == MODE_ASYNC10) || (modeBits == MODE_TMR11);

    // ============================================================
    // Sixteen-times baud tick
    // oscillator divide gives /32 or /64 after the slice counter
    wire   oscTick  = (oscDiv_r == (baudDbl_r ? `OSC_DIV_FAST : `OSC_DIV_SLOW));
    // timer overflow halved unless doubled, giving /16 or /32
    wire   tmrTick  = timerOverflow && (baudDbl_r || tmrHalf_r);
    wire   tick     = isAsync && (useTimer ? tmrTick : oscTick);
    wire   txRoll   = tick && (txSlice_r == `SLICE_LAST);
    wire   rxRoll   = tick && (rxSlice_r == `SLICE_LAST);
    // stop bit leaves on this rollover, so the done flag rises with it
    // Raising it one rollover later would cost a whole bit time per frame
    wire   txStopOut = txRoll && txBusy_r && (txCount_r == 4'h1);

    // ============================================================
    // Receive decisions
    // two-of-three majority
    wire   bitVal   = majority3(vote_r);
    wire   fallEdge = rxPrev_r && !rxLine;
    wire   lastRx   = rxRoll && (rxState_r == RX_DATA) &&
                      (rxCount_r == (is11 ? `FRAME11_BITS - 4'h2 : `FRAME10_BITS - 4'h2));
    // The slot voted at the last rollover is the stop bit in both lengths
    wire   stopBit  = bitVal;
    // Eleven-bit frames keep the ninth bit above the byte; ten-bit ones do not
    wire   ninthBit = is11 ? rxShift_r[8] : bitVal;
    wire   [7:0] rxByte = is11 ? rxShift_r[7:0] : rxShift_r[8:1];
    wire   addrHit  = byteMatch(rxByte, givenAddr_r) || byteMatch(rxByte, bcastAddr_r);
    // sampled one in stop slot is valid
    wire   stopOk   = (stopBit == `STOP_BIT);
    // nine-bit modes need ninth high and match
    // address frames carry ninth bit high
    wire   mp11Pass = (ninthBit == 1'b1) && addrHit;
    // ten-bit modes need valid stop and match
    wire   mp10Pass = stopOk && addrHit;
    wire   mpPass   = !mpEn_r || (is11 ? mp11Pass : mp10Pass);
    wire   rxAccept = lastRx && mpPass;

    // ============================================================
    // Read mux; bit seven chooses error flag or select bit
    wire   bit7     = feAccSel_r ? frameErr_r : msLo_r;
    wire   [7:0] sctlRd = {bit7, msHi_r, mpEn_r, rxEn_r, tx9_r, rx9_r, txDone_r, rxDone_r};
    wire   [31:0] rdMux =
        (haddr == `OFF_SCTL)  ? {24'h000000, sctlRd} :
        (haddr == `OFF_SERIAL_BUFFER)  ? {24'h000000, rxBuf_r} :
        (haddr == `OFF_PWR)   ? {24'h000000, baudDbl_r, feAccSel_r, 6'h00} :
        (haddr == `OFF_ADDR)  ? {24'h000000, givenAddr_r} :
        (haddr == `OFF_BCAST) ? {24'h000000, bcastAddr_r} : 32'h00000000;

    // ============================================================
    // Bus data phase and read data register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 12'h000;
            hrdata   <= 32'h00000000;
        end else begin
            wrPend_r <= busWrite;
            wrAddr_r <= busTake ? haddr : wrAddr_r;
            hrdata   <= (busTake && !hwrite) ? rdMux : hrdata;
        end
    end

    // ============================================================
    // Control register writes; hardware sets win over clears
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            msLo_r      <= 1'b0;
            msHi_r      <= 1'b0;
            mpEn_r      <= 1'b0;
            rxEn_r      <= 1'b0;
            tx9_r       <= 1'b0;
            frameErr_r  <= 1'b0;
            feAccSel_r  <= 1'b0;
            baudDbl_r   <= 1'b0;
            givenAddr_r <= 8'h00;
            bcastAddr_r <= 8'h00;
            txBuf_r     <= 8'h00;
        end else begin
            if (wrSctl) begin
                msHi_r <= hwdata[`B_MSHI];
                mpEn_r <= hwdata[`B_MPEN];
                rxEn_r <= hwdata[`B_RXEN];
                tx9_r  <= hwdata[`B_TX9];
                // bit seven steered by access select
                if (!feAccSel_r) begin
                    msLo_r <= hwdata[`B_MSLO];
                end
            end
            // only set by hardware, set beats clear
            if (lastRx && !stopOk) begin
                frameErr_r <= 1'b1;
            end else if (wrSctl && feAccSel_r && !hwdata[`B_MSLO]) begin
                frameErr_r <= 1'b0;
            end
            if (wrPwr) begin
                baudDbl_r  <= hwdata[`B_BDBL];
                feAccSel_r <= hwdata[`B_FEACC];
            end
            if (wrGiven) givenAddr_r <= hwdata[7:0];
            if (wrBcast) bcastAddr_r <= hwdata[7:0];
            if (wrSbuf) txBuf_r <= hwdata[7:0];
        end
    end

    // ============================================================
    // Completion flags; set wins over a software clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txDone_r <= 1'b0;
            rxDone_r <= 1'b0;
            rx9_r    <= 1'b0;
            rxBuf_r  <= 8'h00;
        end else begin
            txDone_r <= txStopOut ? 1'b1 :
                        (wrSctl ? hwdata[`B_TXDONE] & txDone_r : txDone_r);
            rxDone_r <= rxAccept ? 1'b1 :
                        (wrSctl ? hwdata[`B_RXDONE] & rxDone_r : rxDone_r);
            if (rxAccept) begin
                rx9_r   <= ninthBit;
                rxBuf_r <= rxByte;
            end else if (wrSctl) begin
                rx9_r <= hwdata[`B_RX9];
            end
        end
    end

    // ============================================================
    // Baud prescale
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oscDiv_r  <= 5'h00;
            tmrHalf_r <= 1'b0;
            txSlice_r <= 4'h0;
        end else begin
            oscDiv_r  <= oscTick ? 5'h00 : oscDiv_r + 5'h01;
            tmrHalf_r <= timerOverflow ? ~tmrHalf_r : tmrHalf_r;
            txSlice_r <= tick ? txSlice_r + 4'h1 : txSlice_r;
        end
    end

    // ============================================================
    // Transmitter
    // bits change only on slice rollover; a write only forces the line idle
    // shift start, data LSB first, ninth, stop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txBusy_r  <= 1'b0;
            txArm_r   <= 1'b0;
            txCount_r <= 4'h0;
            txShift_r <= 10'h3FF;
            txdPin    <= `IDLE_LINE;
        // Rewriting the buffer mid-frame abandons the frame in flight
        end else if (wrSbuf && isAsync) begin
            txArm_r   <= 1'b1;
            txBusy_r  <= 1'b0;
            txdPin    <= `IDLE_LINE;
        end else if (txRoll && txArm_r) begin
            txArm_r   <= 1'b0;
            txBusy_r  <= 1'b1;
            txdPin    <= `START_BIT;
            txShift_r <= is11 ? {`STOP_BIT, tx9_r, txBuf_r} : {`STOP_BIT, `STOP_BIT, txBuf_r};
            txCount_r <= is11 ? `FRAME11_BITS - 4'h1 : `FRAME10_BITS - 4'h1;
        end else if (txRoll && txBusy_r) begin
            txdPin    <= (txCount_r == 4'h0) ? `IDLE_LINE : txShift_r[0];
            txShift_r <= {`STOP_BIT, txShift_r[9:1]};
            txCount_r <= txCount_r - 4'h1;
            txBusy_r  <= (txCount_r != 4'h0);
        end
    end

    // ============================================================
    // Receiver
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rxState_r <= RX_IDLE;
            rxSlice_r <= 4'h0;
            rxCount_r <= 4'h0;
            rxShift_r <= 9'h000;
            vote_r    <= 3'h7;
            rxPrev_r  <= `IDLE_LINE;
        end else begin
            rxPrev_r <= rxLine;
            if (tick && rxSlice_r == `VOTE_S0) vote_r[0] <= rxLine;
            if (tick && rxSlice_r == `VOTE_S1) vote_r[1] <= rxLine;
            if (tick && rxSlice_r == `VOTE_S2) vote_r[2] <= rxLine;
            unique case (rxState_r)
                RX_IDLE: begin
                    rxSlice_r <= tick ? rxSlice_r + 4'h1 : rxSlice_r;
                    // enabled receiver starts on falling edge
                    if (rxEn_r && isAsync && fallEdge) begin
                        rxSlice_r <= 4'h0;
                        rxCount_r <= 4'h0;
                        rxState_r <= RX_START;
                    end
                end
                RX_START: begin
                    rxSlice_r <= tick ? rxSlice_r + 4'h1 : rxSlice_r;
                    // False start bit returns to idle
                    if (rxRoll) rxState_r <= bitVal ? RX_IDLE : RX_DATA;
                end
                RX_DATA: begin
                    rxSlice_r <= tick ? rxSlice_r + 4'h1 : rxSlice_r;
                    if (rxRoll) begin
                        rxShift_r <= {bitVal, rxShift_r[8:1]};
                        rxCount_r <= rxCount_r + 4'h1;
                        if (lastRx) rxState_r <= RX_IDLE;
                    end
                end
                default: rxState_r <= RX_IDLE;
            endcase
        end
    end
endmodule

// ---- rtl/serial_port_consts.svh ----
// Constants for the nine-bit asynchronous serial port
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// ============================================================
// Register byte offsets
`define OFF_SCTL        12'h000
`define OFF_SERIAL_BUFFER        12'h004
`define OFF_PWR         12'h008
`define OFF_ADDR        12'h00C
`define OFF_BCAST       12'h010
`define OFF_TOVF        12'h014

// ============================================================
// Serial control bit positions
`define B_RXDONE        0
`define B_TXDONE        1
`define B_RX9           2
`define B_TX9           3
`define B_RXEN          4
`define B_MPEN          5
`define B_MSHI          6
`define B_MSLO          7
// Power control bit positions
`define B_FEACC         6
`define B_BDBL          7

// ============================================================
// Timing counts
`define SLICE_LAST      4'hF
`define VOTE_S0         4'h7
`define VOTE_S1         4'h8
`define VOTE_S2         4'h9
`define FRAME11_BITS    4'hB
`define FRAME10_BITS    4'hA
`define OSC_DIV_SLOW    5'h03
`define OSC_DIV_FAST    5'h01
`define TMR_DIV_SLOW    1'h1
`define IDLE_LINE       1'h1
`define STOP_BIT        1'h1
`define START_BIT       1'h0

`endif

// ---- rtl/serial_port_pkg.sv ----
// Types shared by the serial port design
package serial_port_pkg;
    typedef enum logic [1:0] {
        MODE_SYNC   = 2'h0,
        MODE_ASYNC10 = 2'h1,
        MODE_OSC11  = 2'h2,
        MODE_TMR11  = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'h0,
        RX_START = 2'h1,
        RX_DATA  = 2'h2
    } rx_state_t;
endpackage

// ---- rtl/rx_sync.sv ----
// Two-flop synchroniser for an asynchronous pin
`timescale 1ns/100ps
module rx_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      pinSync
);
    logic stage1_r;

    // ============================================================
    // Synchroniser
    // Line idles high, so reset to one avoids a false start
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1_r <= 1'b1;
            pinSync  <= 1'b1;
        end else begin
            stage1_r <= pinIn;
            pinSync  <= stage1_r;
        end
    end
endmodule

// ---- testbench/serial_port_properties.sv ----
// Port-level checks for the nine-bit serial port
`timescale 1ns/100ps
`include "serial_port_consts.svh"
module serial_port_properties (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        txdPin
);
    logic        take, fast, aWr_r, aRd_r, modeHi_r, modeLo_r, bdbl_r, feAcc_r, txUsed_r;
    logic [11:0] aAdr_r;
    logic [8:0]  cnt_r;

    // Frame timing is only checked at the fast oscillator rate
    assign take = hsel & hready & htrans[1];
    assign fast = modeHi_r & ~modeLo_r & bdbl_r;

    // Shadow of the mode bits, taken in the write data phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {aWr_r, aRd_r, modeHi_r, modeLo_r, bdbl_r, feAcc_r, txUsed_r} <= '0;
            aAdr_r <= '0;
        end else begin
            aWr_r <= take & hwrite;
            aRd_r <= take & ~hwrite;
            aAdr_r <= haddr;
            if (aWr_r && aAdr_r == `OFF_SCTL) modeHi_r <= hwdata[`B_MSHI];
            if (aWr_r && aAdr_r == `OFF_SCTL && !feAcc_r) modeLo_r <= hwdata[`B_MSLO];
            if (aWr_r && aAdr_r == `OFF_PWR) {bdbl_r, feAcc_r} <= hwdata[7:6];
            if (aWr_r && aAdr_r == `OFF_SERIAL_BUFFER) txUsed_r <= 1'b1;
        end
    end

    // Cycles since the start bit fell; a frame is 352 cycles
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) cnt_r <= '0;
        else if (cnt_r != 9'h000) cnt_r <= (cnt_r == 9'h15F) ? 9'h000 : cnt_r + 9'h001;
        else if (fast && txUsed_r && $past(txdPin) && !txdPin) cnt_r <= 9'h001;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ============================================================
    // Assertions
    ready_okay_a: assert property (hreadyout && !hresp) else $error("slave stalled or erred");
    rdata_hold_a: assert property (!aRd_r |-> $stable(hrdata)) else $error("read data moved");
    unmapped_zero_a: assert property (aRd_r && aAdr_r > `OFF_TOVF |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    mode_alias_a: assert property (
        aRd_r && aAdr_r == `OFF_SCTL && !$past(feAcc_r) |->
        hrdata[`B_MSLO] == $past(modeLo_r) && hrdata[`B_MSHI] == $past(modeHi_r))
        else $error("control bit seven alias wrong");
    idle_high_a: assert property (!txUsed_r |-> txdPin) else $error("line left idle");
    start_soon_a: assert property (
        aWr_r && aAdr_r == `OFF_SERIAL_BUFFER && fast && cnt_r == 9'h000 |-> ##[1:80] !txdPin)
        else $error("start bit late");
    bit_edge_a: assert property (
        $changed(txdPin) && cnt_r != 9'h000 |-> cnt_r[4:0] == 5'h00)
        else $error("line moved off a bit boundary");
    start_low_a: assert property (cnt_r == 9'h010 |-> !txdPin) else $error("start high");
    stop_high_a: assert property (cnt_r == 9'h150 |-> txdPin) else $error("stop low");
    tx_frame_c: cover property (cnt_r == 9'h150);
    ctl_read_c: cover property (aRd_r && aAdr_r == `OFF_SCTL);
    bad_addr_c: cover property (aRd_r && aAdr_r > `OFF_TOVF);
endmodule

bind async_serial_port_nine_bit serial_port_properties chk_u (.sys_clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .txdPin);

// ---- testbench/serial_partner.sv ----
// Behavioural far node: sends on the receive line, listens on transmit
`timescale 1ns/100ps
module serial_partner (
    input  wire logic txdPin,
    output logic      rxdPin
);
    int          bitNs = 1600;
    int          gotCnt = 0;
    logic [10:0] gotFrame = '0;

    initial rxdPin = 1'b1;

    // start low, LSB first, stop chosen by caller
    task automatic send(input logic [8:0] word, input logic stopBit, input int len);
        logic [10:0] f;
        f = {1'b1, word, 1'b0};
        f[len-1] = stopBit;
        for (int i = 0; i < len; i++) begin
            rxdPin = f[i];
            #(bitNs);
        end
        rxdPin = 1'b1;
        #(bitNs);
    endtask

    // Mid-bit sampling; no wait after the stop so back-to-back frames are caught
    always @(negedge txdPin) begin
        #(bitNs / 2);
        for (int i = 0; i < 11; i++) begin
            gotFrame[i] = txdPin;
            if (i < 10) #(bitNs);
        end
        gotCnt++;
    end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the nine-bit serial port
`timescale 1ns/100ps
`include "serial_port_consts.svh"
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        timerOverflow = 1'b0;
    logic        hready, hreadyout, hresp, rxdPin, txdPin;
    logic [31:0] hrdata, rd;
    int          errorCnt = 0;
    int          cmpCount = 0;

    // Overflow every second cycle gives 32-cycle bits when doubled
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) timerOverflow <= ~timerOverflow;
    assign hready = hreadyout;

    async_serial_port_nine_bit dut_u (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timerOverflow,
        .rxdPin, .txdPin);
    serial_partner peer_u (.txdPin, .rxdPin);

    // ============================================================
    // Helpers
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
        do @(posedge sys_clk); while (hready !== 1'b1 && ++n < 50);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        do @(posedge sys_clk); while (hready !== 1'b1 && ++n < 100);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        if (errorCnt == 0 && cmpCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ============================================================
    // Scenarios
    // Transmit at both oscillator rates
    task automatic testTx();
        int n;
        for (int b = 0; b < 2; b++) begin
            peer_u.bitNs = b ? 1600 : 3200;
            bus(`OFF_PWR, 1'b1, b ? 32'h80 : 32'h00);
            bus(`OFF_SCTL, 1'b1, 32'h48);
            n = peer_u.gotCnt;
            bus(`OFF_SERIAL_BUFFER, 1'b1, 32'hA5);
            for (int i = 0; i < 2000 && peer_u.gotCnt == n; i++) @(posedge sys_clk);
            chk("txFrame", peer_u.gotFrame, {1'b1, 1'b1, 8'hA5, 1'b0});
            rd = '0;
            for (int i = 0; i < 40 && rd[`B_TXDONE] !== 1'b1; i++) bus(`OFF_SCTL, 1'b0, 0);
            chk("txDone", rd[`B_TXDONE], 1'b1);
        end
    endtask
    // Framing error alias, stickiness and software clear
    task automatic testErr();
        bus(`OFF_SCTL, 1'b1, 32'h58);
        peer_u.send(9'h13C, 1'b1, 11);
        bus(`OFF_SERIAL_BUFFER, 1'b0, 0);
        chk("rxByte", rd[7:0], 8'h3C);
        bus(`OFF_SCTL, 1'b0, 0);
        chk("rxCtl", rd[7:0], 8'h5D);
        peer_u.send(9'h03C, 1'b0, 11);
        bus(`OFF_SCTL, 1'b0, 0);
        chk("modeLo", rd[`B_MSLO], 1'b0);
        bus(`OFF_PWR, 1'b1, 32'hC0);
        bus(`OFF_SCTL, 1'b0, 0);
        chk("frameErr", rd[`B_MSLO], 1'b1);
        peer_u.send(9'h03C, 1'b1, 11);
        bus(`OFF_SCTL, 1'b0, 0);
        chk("errSticky", rd[`B_MSLO], 1'b1);
        bus(`OFF_SCTL, 1'b1, 32'h58);
        bus(`OFF_SCTL, 1'b0, 0);
        chk("errClear", rd[`B_MSLO], 1'b0);
        bus(`OFF_PWR, 1'b1, 32'h80);
    endtask
    // Address filter, enable and ten-bit rows, timer paced
    task automatic testTable();
        logic [7:0] ctl [9] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hD0, 8'hC0, 8'hB0, 8'hB0, 8'h90};
        logic [8:0] wrd [9] = '{9'h15A, 9'h033, 9'h133, 9'h1FF, 9'h033, 9'h011, 9'h05A,
                                9'h033, 9'h0C3};
        logic       hit [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        int         len;
        bus(`OFF_ADDR, 1'b1, 32'h5A);
        bus(`OFF_BCAST, 1'b1, 32'hFF);
        for (int i = 0; i < 9; i++) begin
            len = (i > 5) ? 10 : 11;
            bus(`OFF_SCTL, 1'b1, {24'h0, ctl[i]});
            peer_u.send(wrd[i], 1'b1, len);
            bus(`OFF_SCTL, 1'b0, 0);
            chk("rxDone", rd[`B_RXDONE], hit[i]);
            if (hit[i]) begin
                chk("rxNinth", rd[`B_RX9], (len == 10) | wrd[i][8]);
                bus(`OFF_SERIAL_BUFFER, 1'b0, 0);
                chk("rxData", rd[7:0], wrd[i][7:0]);
            end
        end
    endtask

    // Main sequence; watchdog allows several times the expected run
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        bus(12'h020, 1'b0, 0);
        chk("unmapped", rd, 32'h0);
        testTx();
        testErr();
        testTable();
        conclude();
    end
    initial begin
        #3000000;
        errorCnt++;
        conclude();
    end
endmodule
